// file: core/spbf_consts.vh
// Constants for the byte-framed serial slave
`ifndef SPBF_CONSTS_VH
`define SPBF_CONSTS_VH
`define SPBF_BYTE_BITS     8
`define SPBF_CNT_W         3
`define SPBF_CNT_ZERO      3'h0
`define SPBF_CNT_LAST      3'h7
`define SPBF_CNT_ONE       3'h1
`define SPBF_BYTE_ZERO     8'h00
`define SPBF_SEL_IDLE      1'b1
`define SPBF_ST_IDLE       1'b0
`define SPBF_ST_ACTIVE     1'b1
`define SPBF_HOLD_NS       200
`define SPBF_CLK_NS        8
`endif

// file: core/spbf_sync.v
// Two-flop synchroniser for one external level
module spbf_sync #(
  parameter RESET_VAL = 1'b0
) (
  // Clock and reset
  input  wire clk_i,
  input  wire arst_n_i,
  // Level in and out
  input  wire d_i,
  output reg  q_o
);
  reg meta;

  always @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      meta <= RESET_VAL;
      q_o  <= RESET_VAL;
    end
    else
    begin
      meta <= d_i;
      q_o  <= meta;
    end
  end
endmodule // spbf_sync

// file: core/spbf_slave.v
// Byte-framed serial slave with daisy-chain shift register
`include "spbf_consts.vh"
module spbf_slave #(
  parameter WIDTH = `SPBF_BYTE_BITS
) (
  // Clock and reset
  input  wire             clk_i,
  input  wire             arst_n_i,
  // Serial pins
  input  wire             sclk_i,
  input  wire             master_chip_select_n_i,
  input  wire             sdi_i,
  output reg              sdo_o,
  output reg              sdo_oe_o,
  // Response side
  input  wire [WIDTH-1:0] resp_data_i,
  // Command side
  output reg  [WIDTH-1:0] cmd_data_o,
  output reg              cmd_valid_o,
  output reg              frame_length_error_flag_o,
  input  wire             err_clear_i
);
  // =====================================================
  // Input synchronisers
  // =====================================================
  localparam [0:0] ST_IDLE   = `SPBF_ST_IDLE;
  localparam [0:0] ST_ACTIVE = `SPBF_ST_ACTIVE;

  wire                   sclk_s;
  wire                   sel_n_s;
  wire                   sdi_s;
  reg                    sclk_d;
  reg                    sel_n_d;
  reg                    state;
  reg                    next_state;
  reg  [`SPBF_CNT_W-1:0] bit_cnt;
  reg  [`SPBF_CNT_W-1:0] next_bit_cnt;
  reg                    byte_seen;
  reg                    next_byte_seen;
  reg  [WIDTH-1:0]       shreg;
  reg  [WIDTH-1:0]       next_shreg;

  spbf_sync #(.RESET_VAL(1'b0)) u_sclk (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .d_i      (sclk_i),
    .q_o      (sclk_s)
  );

  spbf_sync #(.RESET_VAL(`SPBF_SEL_IDLE)) u_sel (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .d_i      (master_chip_select_n_i),
    .q_o      (sel_n_s)
  );

  spbf_sync #(.RESET_VAL(1'b0)) u_sdi (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .d_i      (sdi_i),
    .q_o      (sdi_s)
  );

  // =====================================================
  // Edge detection
  // =====================================================
  wire sclk_fall = sclk_d & ~sclk_s;
  wire sclk_rise = ~sclk_d & sclk_s;
  wire sel_fall  = sel_n_d & ~sel_n_s;
  wire sel_rise  = ~sel_n_d & sel_n_s;
  wire active    = (state == ST_ACTIVE);
  wire whole     = (bit_cnt == `SPBF_CNT_ZERO) & byte_seen;
  wire frame_end = active & sel_rise;
  wire frame_ok  = frame_end & whole;
  wire frame_bad = frame_end & ~whole;

  always @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      sclk_d  <= 1'b0;
      sel_n_d <= `SPBF_SEL_IDLE;
    end
    else
    begin
      sclk_d  <= sclk_s;
      sel_n_d <= sel_n_s;
    end
  end

  // =====================================================
  // Frame state, counter and shift register
  // =====================================================
  always @*
  begin
    next_state     = state;
    next_bit_cnt   = bit_cnt;
    next_byte_seen = byte_seen;
    next_shreg     = shreg;
    case (state)
      ST_IDLE:
      begin
        if (sel_fall)
        begin
          next_state     = ST_ACTIVE;
          next_bit_cnt   = `SPBF_CNT_ZERO;
          next_byte_seen = 1'b0;
          next_shreg     = resp_data_i;
        end
      end
      ST_ACTIVE:
      begin
        if (sel_rise)
          next_state = ST_IDLE;
        else if (sclk_fall)
        begin
          next_shreg   = {shreg[WIDTH-2:0], sdi_s};
          next_bit_cnt = bit_cnt + `SPBF_CNT_ONE;
          if (bit_cnt == `SPBF_CNT_LAST)
            next_byte_seen = 1'b1;
        end
      end
      default:
        next_state = ST_IDLE;
    endcase
  end

  always @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state     <= ST_IDLE;
      bit_cnt   <= `SPBF_CNT_ZERO;
      byte_seen <= 1'b0;
      shreg     <= `SPBF_BYTE_ZERO;
    end
    else
    begin
      state     <= next_state;
      bit_cnt   <= next_bit_cnt;
      byte_seen <= next_byte_seen;
      shreg     <= next_shreg;
    end
  end

  // =====================================================
  // Serial output
  // =====================================================
  always @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      sdo_o    <= 1'b0;
      sdo_oe_o <= 1'b0;
    end
    else if (!active || sel_rise)
    begin
      sdo_oe_o <= 1'b0;
      if (sel_fall)
      begin
        sdo_oe_o <= 1'b1;
        sdo_o    <= sdi_s;
      end
    end
    else if (sclk_rise)
      sdo_o <= shreg[WIDTH-1];
  end

  // =====================================================
  // Command hand-over
  // =====================================================
  always @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cmd_data_o  <= `SPBF_BYTE_ZERO;
      cmd_valid_o <= 1'b0;
    end
    else
    begin
      cmd_valid_o <= 1'b0;
      if (frame_ok)
      begin
        cmd_data_o  <= shreg;
        cmd_valid_o <= 1'b1;
      end
    end
  end

  // =====================================================
  // Length error flag
  // =====================================================
  always @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      frame_length_error_flag_o <= 1'b0;
    else if (frame_bad)
      frame_length_error_flag_o <= 1'b1;
    else if (err_clear_i)
      frame_length_error_flag_o <= 1'b0;
  end
endmodule // spbf_slave

// file: bench/spbf_asserts.sv
// Assertions on the byte-framed serial slave ports
module spbf_asserts #(parameter WIDTH = 8) (
  // Clock, reset and driven pins
  input logic             clk_i,
  input logic             arst_n_i,
  input logic             master_chip_select_n_i,
  input logic             err_clear_i,
  // Watched outputs
  input logic             sdo_oe_o,
  input logic             cmd_valid_o,
  input logic             frame_length_error_flag_o,
  input logic [WIDTH-1:0] cmd_data_o
);
  timeunit 1ns / 1ps;
  wire cs = master_chip_select_n_i;
  wire f  = frame_length_error_flag_o;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  sequence s_fall; $fell(cs); endsequence
  property p_pulse; cmd_valid_o |=> !cmd_valid_o; endproperty
  a_pulse: assert property (p_pulse) else $error("long valid");
  property p_idle; cmd_valid_o |-> cs; endproperty
  a_idle: assert property (p_idle) else $error("early valid");
  property p_hold; !cmd_valid_o |-> $stable(cmd_data_o); endproperty
  a_hold: assert property (p_hold) else $error("data moved");
  property p_bad; $rose(f) |-> !cmd_valid_o; endproperty
  a_bad: assert property (p_bad) else $error("bad taken");
  property p_stick; f && !err_clear_i |=> f; endproperty
  a_stick: assert property (p_stick) else $error("flag lost");
  property p_hiz; cs [*6] |-> !sdo_oe_o; endproperty
  a_hiz: assert property (p_hiz) else $error("idle drive");
  property p_on; s_fall ##1 !cs [*5] |-> sdo_oe_o; endproperty
  a_on: assert property (p_on) else $error("no drive");
  property p_off; cmd_valid_o |-> ##[0:2] !sdo_oe_o; endproperty
  a_off: assert property (p_off) else $error("late off");
endmodule // spbf_asserts

bind spbf_slave spbf_asserts #(.WIDTH(WIDTH)) i_chk (.clk_i, .arst_n_i,
  .master_chip_select_n_i, .err_clear_i, .sdo_oe_o, .cmd_valid_o,
  .frame_length_error_flag_o, .cmd_data_o);

// file: bench/spbf_mst.sv
// Bus master model for the serial slave
module spbf_mst (
  // Clock and returned data
  input  logic clk_i,
  input  logic sdo_i,
  // Link pins towards the slave
  output logic sclk_o = 1'b0,
  output logic cs_n_o = 1'b1,
  output logic sdi_o  = 1'b0
);
  timeunit 1ns / 1ps;
  task automatic xfer(input int n, input bit sel, input logic [15:0] d,
                      output logic [15:0] q);
    q = '0;
    @(posedge clk_i) cs_n_o <= !sel;
    repeat (32) @(posedge clk_i);
    for (int i = n - 1; i >= 0; i--)
    begin
      sdi_o  <= d[i];
      sclk_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      sclk_o <= 1'b0;
      repeat (4) @(posedge clk_i);
      q[i] = sdo_i;
    end
    repeat (32) @(posedge clk_i);
    cs_n_o <= 1'b1;
    sdi_o  <= ~sdi_o;
    repeat (140) @(posedge clk_i);
  endtask
endmodule // spbf_mst

// file: bench/testbench.sv
// Self-checking bench for the byte-framed serial slave
module testbench;
  timeunit 1ns / 1ps;
  logic        clk_i = 0, arst_n_i = 0, clr = 0, sclk, cs_n, sdi, sdo, oe, vld, flag, good;
  logic [7:0]  resp = 0, cmd, exp_q[$];
  logic [15:0] d, q;
  int          fails = 0, n_checks = 0, ns[8] = '{5, 0, 7, 9, 8, 16, 8, 16};
  initial forever #4 clk_i = ~clk_i;
  spbf_slave i_dut (.clk_i, .arst_n_i, .sclk_i(sclk), .master_chip_select_n_i(cs_n),
    .sdi_i(sdi), .sdo_o(sdo), .sdo_oe_o(oe), .resp_data_i(resp), .cmd_data_o(cmd),
    .cmd_valid_o(vld), .frame_length_error_flag_o(flag), .err_clear_i(clr));
  spbf_mst i_mst (.clk_i, .sdo_i(oe ? sdo : !sdo), .sclk_o(sclk), .cs_n_o(cs_n),
    .sdi_o(sdi));
  task chk(input logic [15:0] s, e);
    n_checks++;
    if (s !== e)
    begin
      fails++;
      $display("MISMATCH %0t %h %h", $time, s, e);
    end
  endtask
  task finish_test;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk_i)
    if (vld === 1'b1)
    begin
      chk(16'(exp_q.size() != 0), 16'h0001);
      if (exp_q.size() != 0)
        chk(cmd, exp_q.pop_front());
    end
  initial
  begin
    #100us;
    fails++;
    finish_test;
  end
  initial
  begin
    void'($urandom(32'h8388));
    repeat (20) @(posedge clk_i);
    arst_n_i <= 1;
    foreach (ns[i])
    begin
      d = 16'($urandom);
      resp <= 8'($urandom);
      good = ns[i] % 8 == 0 && ns[i] > 0;
      if (good)
        exp_q.push_back(d[7:0]);
      i_mst.xfer(ns[i], i > 0, d, q);
      chk(flag, !good && i > 0);
      if (good)
        chk(q, {resp, d[15:8]} >> (16 - ns[i]));
      chk(16'(exp_q.size()), 16'h0000);
      clr <= 1;
      @(posedge clk_i) clr <= 0;
    end
    finish_test;
  end
endmodule // testbench
